/* fcc_map.svh */
// Opcodes, status field positions and timing figures of the control unit
`ifndef FCC_MAP_SVH
`define FCC_MAP_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define FCC_OP_RESET_ARM 8'h66
`define FCC_OP_RESET 8'h99
`define FCC_OP_QUAD_ENTER 8'h38
`define FCC_OP_QUAD_EXIT 8'hFF
`define FCC_OP_LATCH_SET 8'h06
`define FCC_OP_LATCH_CLEAR 8'h04
`define FCC_OP_VOL_ENABLE 8'h50
`define FCC_OP_STATUS_WRITE 8'h01
`define FCC_OP_STATUS_READ 8'h05
`define FCC_OP_PLAIN_READ 8'h03
`define FCC_OP_DUAL_OUT_READ 8'h3B
`define FCC_OP_DUAL_IO_READ 8'hBB
`define FCC_OP_QUAD_PROGRAM 8'h32

// ----------------------------------------------------------------
// Status byte layout
// ----------------------------------------------------------------
`define FCC_SB_BUSY 0
`define FCC_SB_LATCH 1
`define FCC_SB_VOL_LO 2
`define FCC_SB_VOL_HI 7
`define FCC_SB_RESERVED_OTP 2
`define FCC_STATUS_RESET 8'h00

// ----------------------------------------------------------------
// Frame lengths in link clock edges
// ----------------------------------------------------------------
`define FCC_EDGES_OP_SER 6'h08
`define FCC_EDGES_OP_QUAD 6'h02
`define FCC_EDGES_DAT_SER 6'h10
`define FCC_EDGES_DAT_QUAD 6'h04

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FCC_CLK_MHZ 250
`define FCC_RESET_RECOVERY_NS 28000
`define FCC_RESET_RECOVERY_CYC ((`FCC_RESET_RECOVERY_NS * `FCC_CLK_MHZ) / 1000)

`endif

/* fcc_pkg.sv */
// Types shared by the flash control command unit
package fcc_pkg;

  // Everything the link side gathered during one chip-select frame
  typedef struct packed {
    logic [7:0] op_ser;
    logic [7:0] op_quad;
    logic [7:0] dat_ser;
    logic [7:0] dat_quad;
    logic [5:0] edges;
  } fcc_frame_t;

  // Command handed on to the array read/program/erase engine
  typedef struct packed {
    logic valid;
    logic quad;
    logic [7:0] opcode;
  } fcc_cmd_t;

  // Non-volatile status write request
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fcc_nv_write_t;

  typedef enum logic [2:0] {
    FCC_IDLE = 3'b001,
    FCC_GRAB = 3'b010,
    FCC_EXEC = 3'b100
  } fcc_state_t;

endpackage

/* fcc_ctl_unit.sv */
// Control command unit: reset pair, quad mode, write latch, status byte
`include "fcc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module fcc_ctl_unit
  import fcc_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = `FCC_RESET_RECOVERY_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_out,
  input wire logic op_busy_in,
  input wire logic op_done_in,
  input wire logic otp_mode_in,
  input wire logic enh_mode_in,
  input wire logic [7:0] nv_status_in,
  output logic [7:0] flash_status_byte_out,
  output logic quad_cmd_mode_out,
  output fcc_cmd_t cmd_out,
  output fcc_nv_write_t nv_write_out,
  output logic op_abort_out,
  output logic enh_exit_out,
  output logic otp_exit_out,
  output logic dpd_release_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] pick(input logic quad,
                                      input logic [7:0] q,
                                      input logic [7:0] s);
    pick = quad ? q : s;
  endfunction

  function automatic logic edges_at_least(input logic quad,
                                          input logic [5:0] e,
                                          input logic [5:0] nq,
                                          input logic [5:0] ns);
    edges_at_least = quad ? (e >= nq) : (e >= ns);
  endfunction

  function automatic logic refused_in_quad(input logic [7:0] op);
    refused_in_quad = (op == `FCC_OP_PLAIN_READ) ||
                      (op == `FCC_OP_DUAL_OUT_READ) ||
                      (op == `FCC_OP_DUAL_IO_READ) ||
                      (op == `FCC_OP_QUAD_PROGRAM);
  endfunction

  // ----------------------------------------------------------------
  // Link domain: frame capture on rising link clock
  // ----------------------------------------------------------------
  logic first_reg;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [2:0] ph_reg;
  logic [7:0] ser_sh_reg;
  logic [7:0] nib_sh_reg;
  fcc_frame_t frame_reg;
  logic quad_use_reg;
  logic q_s1_reg;
  logic q_s2_reg;
  logic [7:0] st_s1_reg;
  logic [7:0] st_s2_reg;

  // Chip select high arms a fresh frame; the clock may be stopped then
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  always_comb begin
    if (first_reg) begin
      cnt_next = 6'h01;
    end else if (cnt_reg == 6'h3F) begin
      cnt_next = cnt_reg;
    end else begin
      cnt_next = cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge sclk_in) begin
    cnt_reg <= cnt_next;
    ph_reg <= first_reg ? 3'h1 : ph_reg + 3'h1;
    ser_sh_reg <= {ser_sh_reg[6:0], dq_in[0]};
    nib_sh_reg <= {nib_sh_reg[3:0], dq_in};
  end

  // Both widths are captured; the core picks by the mode it holds
  always_ff @(posedge sclk_in) begin
    frame_reg.edges <= cnt_next;
    if (cnt_next == `FCC_EDGES_OP_SER) begin
      frame_reg.op_ser <= {ser_sh_reg[6:0], dq_in[0]};
    end
    if (cnt_next == `FCC_EDGES_DAT_SER) begin
      frame_reg.dat_ser <= {ser_sh_reg[6:0], dq_in[0]};
    end
    if (cnt_next == `FCC_EDGES_OP_QUAD) begin
      frame_reg.op_quad <= {nib_sh_reg[3:0], dq_in};
    end
    if (cnt_next == `FCC_EDGES_DAT_QUAD) begin
      frame_reg.dat_quad <= {nib_sh_reg[3:0], dq_in};
    end
  end

  // Mode settles by the second edge of a frame, before the opcode ends
  always_ff @(posedge sclk_in) begin
    q_s1_reg <= quad_use_reg;
    q_s2_reg <= q_s1_reg;
  end

  // A byte read while busy toggles may mix old and new bits; reread it
  always_ff @(posedge sclk_in) begin
    st_s1_reg <= flash_status_byte_out;
    st_s2_reg <= st_s1_reg;
  end

  // ----------------------------------------------------------------
  // Link domain: status shift out on falling link clock
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      dq_out <= 4'h0;
      dq_oe_out <= 4'h0;
    end else if (q_s2_reg &&
                 frame_reg.op_quad == `FCC_OP_STATUS_READ &&
                 cnt_reg >= `FCC_EDGES_OP_QUAD) begin
      dq_oe_out <= 4'hF;
      dq_out <= ph_reg[0] ? st_s2_reg[3:0] : st_s2_reg[7:4];
    end else if (!q_s2_reg &&
                 frame_reg.op_ser == `FCC_OP_STATUS_READ &&
                 cnt_reg >= `FCC_EDGES_OP_SER) begin
      dq_oe_out <= 4'h2;
      dq_out <= {2'h0, st_s2_reg[~ph_reg], 1'b0};
    end else begin
      dq_out <= 4'h0;
      dq_oe_out <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: frame end detection
  // ----------------------------------------------------------------
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_s3_reg;
  fcc_frame_t sum_reg;
  fcc_state_t state_reg;
  fcc_state_t state_next;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_s3_reg <= 1'b1;
    end else begin
      cs_s1_reg <= cs_n_in;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FCC_IDLE: begin
        if (cs_s2_reg && !cs_s3_reg) begin
          state_next = FCC_GRAB;
        end
      end
      FCC_GRAB: begin
        state_next = FCC_EXEC;
      end
      FCC_EXEC: begin
        state_next = FCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= FCC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Link clock is stopped with chip select high, so the summary is quiet
  always_ff @(posedge ref_clk_in) begin
    if (state_reg == FCC_GRAB) begin
      sum_reg <= frame_reg;
    end
  end

  // ----------------------------------------------------------------
  // Core domain: decode of the finished frame
  // ----------------------------------------------------------------
  logic use_quad;
  logic [7:0] op;
  logic [7:0] dat;
  logic op_whole;
  logic op_alone;
  logic has_data;
  logic exec;

  assign exec = (state_reg == FCC_EXEC);
  // Enhanced read expects the quad form even outside quad mode
  assign use_quad = quad_cmd_mode_out | enh_mode_in;
  assign op = pick(use_quad, sum_reg.op_quad, sum_reg.op_ser);
  assign dat = pick(use_quad, sum_reg.dat_quad, sum_reg.dat_ser);
  assign op_whole = edges_at_least(use_quad, sum_reg.edges,
                                   `FCC_EDGES_OP_QUAD, `FCC_EDGES_OP_SER);
  assign op_alone = use_quad ?
                    (sum_reg.edges == `FCC_EDGES_OP_QUAD) :
                    (sum_reg.edges == `FCC_EDGES_OP_SER);
  assign has_data = edges_at_least(use_quad, sum_reg.edges,
                                   `FCC_EDGES_DAT_QUAD, `FCC_EDGES_DAT_SER);

  logic cmd_ok;
  logic armed_reg;
  logic vol_armed_reg;
  logic do_reset;

  assign cmd_ok = exec && op_whole;
  assign do_reset = cmd_ok && op == `FCC_OP_RESET && armed_reg;

  // ----------------------------------------------------------------
  // Reset pairing
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      armed_reg <= 1'b0;
    end else if (cmd_ok) begin
      armed_reg <= (op == `FCC_OP_RESET_ARM);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || do_reset) begin
      vol_armed_reg <= 1'b0;
    end else if (cmd_ok) begin
      vol_armed_reg <= (op == `FCC_OP_VOL_ENABLE);
    end
  end

  // ----------------------------------------------------------------
  // Bus width modes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || do_reset) begin
      quad_cmd_mode_out <= 1'b0;
    end else if (cmd_ok && op == `FCC_OP_QUAD_ENTER) begin
      quad_cmd_mode_out <= 1'b1;
    end else if (cmd_ok && op_alone && op == `FCC_OP_QUAD_EXIT &&
                 !enh_mode_in) begin
      quad_cmd_mode_out <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      quad_use_reg <= 1'b0;
    end else begin
      quad_use_reg <= use_quad;
    end
  end

  // First FFh only ends enhancement; the next one leaves quad mode
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      enh_exit_out <= 1'b0;
    end else begin
      enh_exit_out <= (cmd_ok && op == `FCC_OP_QUAD_EXIT && enh_mode_in) ||
                      (do_reset && enh_mode_in);
    end
  end

  // ----------------------------------------------------------------
  // Write enable latch and one-time mode exit
  // ----------------------------------------------------------------
  logic latch_reg;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || do_reset) begin
      latch_reg <= 1'b0;
    end else if (cmd_ok && op_alone && op == `FCC_OP_LATCH_SET) begin
      latch_reg <= 1'b1;
    end else if (cmd_ok && op_alone && op == `FCC_OP_LATCH_CLEAR) begin
      latch_reg <= 1'b0;
    end else if (op_done_in) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      otp_exit_out <= 1'b0;
    end else begin
      otp_exit_out <= cmd_ok && op_alone && otp_mode_in &&
                      op == `FCC_OP_LATCH_CLEAR;
    end
  end

  // ----------------------------------------------------------------
  // Volatile status bits and writes
  // ----------------------------------------------------------------
  logic [5:0] vol_reg;
  logic sw_now;

  assign sw_now = cmd_ok && has_data && op == `FCC_OP_STATUS_WRITE;

  // Lands a few core cycles after chip select rises, well inside 50ns
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || do_reset) begin
      vol_reg <= nv_status_in[`FCC_SB_VOL_HI:`FCC_SB_VOL_LO];
    end else if (sw_now && vol_armed_reg) begin
      vol_reg <= dat[`FCC_SB_VOL_HI:`FCC_SB_VOL_LO];
    end
  end

  // Non-volatile write needs the latch and an idle array
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      nv_write_out <= '0;
    end else begin
      nv_write_out.valid <= sw_now && !vol_armed_reg && latch_reg &&
                            !flash_status_byte_out[`FCC_SB_BUSY];
      nv_write_out.data <= dat;
    end
  end

  // ----------------------------------------------------------------
  // Reset side effects and recovery time
  // ----------------------------------------------------------------
  logic [31:0] rec_reg;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rec_reg <= 32'h0000_0000;
    end else if (do_reset && op_busy_in) begin
      rec_reg <= RECOVERY_CYC;
    end else if (rec_reg != 32'h0000_0000) begin
      rec_reg <= rec_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      op_abort_out <= 1'b0;
      dpd_release_out <= 1'b0;
    end else begin
      op_abort_out <= do_reset && op_busy_in;
      dpd_release_out <= do_reset;
    end
  end

  // ----------------------------------------------------------------
  // Status byte
  // ----------------------------------------------------------------
  logic [7:0] status_next;

  always_comb begin
    status_next = {vol_reg, latch_reg,
                   op_busy_in | (rec_reg != 32'h0000_0000)};
    if (otp_mode_in) begin
      status_next[`FCC_SB_RESERVED_OTP] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      flash_status_byte_out <= `FCC_STATUS_RESET;
    end else begin
      flash_status_byte_out <= status_next;
    end
  end

  // ----------------------------------------------------------------
  // Hand-off to the array engine
  // ----------------------------------------------------------------
  logic ctl_op;

  assign ctl_op = (op == `FCC_OP_RESET_ARM) || (op == `FCC_OP_RESET) ||
                  (op == `FCC_OP_QUAD_ENTER) ||
                  (op == `FCC_OP_QUAD_EXIT) ||
                  (op == `FCC_OP_LATCH_SET) ||
                  (op == `FCC_OP_LATCH_CLEAR) ||
                  (op == `FCC_OP_VOL_ENABLE) ||
                  (op == `FCC_OP_STATUS_WRITE) ||
                  (op == `FCC_OP_STATUS_READ);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cmd_out <= '0;
    end else begin
      cmd_out.valid <= cmd_ok && !ctl_op &&
                       !(quad_cmd_mode_out && refused_in_quad(op));
      cmd_out.quad <= use_quad;
      cmd_out.opcode <= op;
    end
  end

endmodule

`default_nettype wire

/* fcc_ctl_unit_properties.sv */
// Port-level assertions for the flash control command unit
`timescale 1ns/10ps
`default_nettype none
module fcc_ctl_unit_properties
  import fcc_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = 7000
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_n_in,
  input wire logic op_done_in,
  input wire logic otp_mode_in,
  input wire logic [7:0] nv_status_in,
  input wire logic [3:0] dq_oe_out,
  input wire logic [7:0] flash_status_byte_out,
  input wire logic quad_cmd_mode_out,
  input wire fcc_cmd_t cmd_out,
  input wire fcc_nv_write_t nv_write_out,
  input wire logic op_abort_out,
  input wire logic enh_exit_out,
  input wire logic dpd_release_out
);
  // --------------------
  // Helper counters
  // --------------------
  logic [3:0] idle_cnt;
  logic [15:0] hold_cnt;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || !cs_n_in) begin
      idle_cnt <= 4'h0;
    end else if (idle_cnt != 4'hF) begin
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
  // Two cycles of slack: the hold is loaded an edge after the pulse rises
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      hold_cnt <= 16'h0000;
    end else if (op_abort_out) begin
      hold_cnt <= 16'(RECOVERY_CYC);
    end else if (hold_cnt != 16'h0000) begin
      hold_cnt <= hold_cnt - 16'h0001;
    end
  end
  // --------------------
  // Properties
  // --------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence otp_steady;
    otp_mode_in ##1 otp_mode_in;
  endsequence
  sequence link_quiet;
    cs_n_in && idle_cnt > 4'h8;
  endsequence
  a_oe_idle: assert property (
    cs_n_in |-> dq_oe_out == 4'h0) else $error("enable while deselected");
  a_otp_reserved: assert property (
    otp_steady |-> !flash_status_byte_out[2]) else $error("reserved bit set");
  a_done_clears: assert property (
    link_quiet ##0 op_done_in |-> ##2 !flash_status_byte_out[1])
    else $error("latch kept after write end");
  a_abort_single: assert property (
    op_abort_out |=> !op_abort_out) else $error("abort pulse too long");
  a_abort_reset: assert property (
    op_abort_out |-> dpd_release_out) else $error("abort without reset");
  a_reset_restores: assert property (
    dpd_release_out |=> !quad_cmd_mode_out && !flash_status_byte_out[1]
      && flash_status_byte_out[7:3] == nv_status_in[7:3])
    else $error("status not restored by reset");
  a_quad_refused: assert property (
    cmd_out.valid && quad_cmd_mode_out |->
      !(cmd_out.opcode inside {8'h03, 8'h3B, 8'hBB, 8'h32}))
    else $error("unsupported opcode forwarded in quad mode");
  a_quad_steady: assert property (
    $changed(quad_cmd_mode_out) |-> cs_n_in)
    else $error("quad mode changed inside a frame");
  a_nv_latch: assert property (
    nv_write_out.valid |-> $past(flash_status_byte_out[1]))
    else $error("status write without latch");
  a_enh_single: assert property (
    enh_exit_out |=> !enh_exit_out) else $error("enhance exit too long");
  a_recovery_busy: assert property (
    hold_cnt > 16'h0002 |-> flash_status_byte_out[0])
    else $error("busy dropped during reset recovery");
endmodule
bind fcc_ctl_unit fcc_ctl_unit_properties #(
  .RECOVERY_CYC(RECOVERY_CYC)
) props (
  .ref_clk_in(ref_clk_in),
  .sys_rst_in(sys_rst_in),
  .cs_n_in(cs_n_in),
  .op_done_in(op_done_in),
  .otp_mode_in(otp_mode_in),
  .nv_status_in(nv_status_in),
  .dq_oe_out(dq_oe_out),
  .flash_status_byte_out(flash_status_byte_out),
  .quad_cmd_mode_out(quad_cmd_mode_out),
  .cmd_out(cmd_out),
  .nv_write_out(nv_write_out),
  .op_abort_out(op_abort_out),
  .enh_exit_out(enh_exit_out),
  .dpd_release_out(dpd_release_out)
);
`default_nettype wire

/* fcc_host_model.sv */
// Host controller model driving the link pins of the control unit
`timescale 1ns/10ps
`default_nettype none
module fcc_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic [3:0] dq_line_out,
  input wire logic [3:0] dq_dev_in,
  input wire logic [3:0] dq_oe_in
);
  logic [3:0] drv;
  logic drv_on;
  // Released lines show the inverse of the last value, never a stale copy
  assign dq_line_out = (dq_oe_in & dq_dev_in) |
                       (~dq_oe_in & (drv_on ? drv : ~drv));
  // Rising chip select at start clears the device's link outputs
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    drv = 4'h0;
    drv_on = 1'b0;
    #1 cs_n_out = 1'b1;
  end
  // --------------------
  // One frame; clock stands still outside it
  // --------------------
  task automatic xfer(input bit quad, input logic [15:0] tx, input int nb,
                      input int rd, output logic [15:0] got);
    int n;
    n = quad ? nb * 2 : nb * 8;
    got = 16'h0000;
    #1.3 cs_n_out = 1'b0;
    drv_on = 1'b1;
    for (int i = 0; i < n; i++) begin
      drv = quad ? tx[15 - 4 * i -: 4] : {3'b000, tx[15 - i]};
      #16 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
    end
    drv_on = 1'b0;
    for (int i = 0; i < rd; i++) begin
      #16 sclk_out = 1'b1;
      got = quad ? {got[11:0], dq_dev_in} : {got[14:0], dq_dev_in[1]};
      #16 sclk_out = 1'b0;
    end
    #16 cs_n_out = 1'b1;
    // Gap covers the deselect minimum and the core's pick-up delay
    #48;
  endtask
endmodule
`default_nettype wire

/* fcc_ctl_unit_bench.sv */
// Self-checking bench for the flash control command unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module fcc_ctl_unit_bench
  import fcc_pkg::*;
();
  typedef struct {
    logic [15:0] tx;
    int nb;
    logic [7:0] exp;
    bit rd;
  } fcc_row_t;
  logic ref_clk, sys_rst, sclk, cs_n, op_busy, op_done, otp_mode, enh_mode;
  logic quad_mode, abort, enh_exit, otp_exit, dpd;
  logic [3:0] dq_line, dq_dev, dq_oe;
  logic [7:0] nv_status, status;
  fcc_cmd_t cmd, last_cmd;
  fcc_nv_write_t nv_wr, last_nv;
  int errors, samples_checked, dpd_cnt, abort_cnt, enh_cnt, otp_cnt, cmd_cnt;
  int nv_cnt, cmd_base;
  // Stateful: each row starts from the status the row before left
  fcc_row_t rows [8] = '{
    '{16'h0600, 1, 8'hA6, 1'b1},
    '{16'h0400, 1, 8'hA4, 1'b1},
    '{16'h5000, 1, 8'hA4, 1'b0},
    '{16'h015C, 2, 8'h5C, 1'b1},
    '{16'h0600, 2, 8'h5C, 1'b0},
    '{16'h0600, 1, 8'h5E, 1'b1},
    '{16'hFF00, 1, 8'h5E, 1'b0},
    '{16'h0133, 2, 8'h5E, 1'b1}
  };
  logic [7:0] refused [4] = '{8'h03, 8'h3B, 8'hBB, 8'h32};
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  fcc_host_model host (
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .dq_line_out(dq_line),
    .dq_dev_in(dq_dev),
    .dq_oe_in(dq_oe)
  );
  fcc_ctl_unit #(
    .RECOVERY_CYC(20)
  ) DUT (
    .ref_clk_in(ref_clk),
    .sys_rst_in(sys_rst),
    .sclk_in(sclk),
    .cs_n_in(cs_n),
    .dq_in(dq_line),
    .dq_out(dq_dev),
    .dq_oe_out(dq_oe),
    .op_busy_in(op_busy),
    .op_done_in(op_done),
    .otp_mode_in(otp_mode),
    .enh_mode_in(enh_mode),
    .nv_status_in(nv_status),
    .flash_status_byte_out(status),
    .quad_cmd_mode_out(quad_mode),
    .cmd_out(cmd),
    .nv_write_out(nv_wr),
    .op_abort_out(abort),
    .enh_exit_out(enh_exit),
    .otp_exit_out(otp_exit),
    .dpd_release_out(dpd)
  );
  always @(posedge ref_clk) begin
    dpd_cnt += (dpd === 1'b1);
    abort_cnt += (abort === 1'b1);
    enh_cnt += (enh_exit === 1'b1);
    otp_cnt += (otp_exit === 1'b1);
    nv_cnt += (nv_wr.valid === 1'b1);
    if (cmd.valid === 1'b1) begin
      cmd_cnt++;
      last_cmd = cmd;
    end
    if (nv_wr.valid === 1'b1) begin
      last_nv = nv_wr;
    end
  end
  // --------------------
  // Tasks
  // --------------------
  task automatic frame(input bit q, input logic [15:0] tx, input int nb);
    logic [15:0] got;
    host.xfer(q, tx, nb, 0, got);
    @(negedge ref_clk);
  endtask
  task automatic rd_status(input bit q, input logic [7:0] exp);
    logic [15:0] got;
    host.xfer(q, 16'h0500, 1, q ? 4 : 16, got);
    @(negedge ref_clk);
    `CHK(got[15:8], exp)
    `CHK(got[7:0], exp)
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    finish_test();
  end
  // --------------------
  // Main sequence
  // --------------------
  initial begin
    sys_rst = 1'b1;
    op_busy = 1'b0;
    op_done = 1'b0;
    otp_mode = 1'b0;
    enh_mode = 1'b0;
    nv_status = 8'hA4;
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    frame(1'b0, 16'h9900, 1);
    `CHK(dpd_cnt, 0)
    `CHK(status, 8'hA4)
    foreach (rows[i]) begin
      frame(1'b0, rows[i].tx, rows[i].nb);
      `CHK(status, rows[i].exp)
      if (rows[i].rd) begin
        rd_status(1'b0, rows[i].exp);
      end
    end
    `CHK(last_nv.data, 8'h33)
    frame(1'b0, 16'h6600, 1);
    frame(1'b0, 16'h0400, 1);
    frame(1'b0, 16'h9900, 1);
    `CHK(dpd_cnt, 0)
    `CHK(status, 8'h5C)
    // Latch is clear here, so a non-volatile write must be refused
    frame(1'b0, 16'h0177, 2);
    `CHK(nv_cnt, 1)
    frame(1'b0, 16'h0600, 1);
    op_done = 1'b1;
    @(negedge ref_clk);
    op_done = 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK(status, 8'h5C)
    otp_mode = 1'b1;
    frame(1'b0, 16'h0600, 1);
    `CHK(status, 8'h5A)
    frame(1'b0, 16'h0400, 1);
    `CHK(otp_cnt, 1)
    `CHK(status, 8'h58)
    otp_mode = 1'b0;
    frame(1'b0, 16'h3800, 1);
    `CHK(quad_mode, 1'b1)
    rd_status(1'b1, 8'h5C);
    cmd_base = cmd_cnt;
    foreach (refused[i]) begin
      frame(1'b1, {refused[i], 8'h00}, 1);
    end
    `CHK(cmd_cnt - cmd_base, 0)
    frame(1'b1, 16'h0B00, 1);
    `CHK(last_cmd, 10'h30B)
    enh_mode = 1'b1;
    frame(1'b1, 16'hFF00, 1);
    `CHK(enh_cnt, 1)
    `CHK(quad_mode, 1'b1)
    enh_mode = 1'b0;
    frame(1'b1, 16'hFF00, 1);
    `CHK(quad_mode, 1'b0)
    // Back into quad mode with a serial 38h, then the reset pair sent in quad form
    frame(1'b0, 16'h3800, 1);
    op_busy = 1'b1;
    frame(1'b1, 16'h6600, 1);
    frame(1'b1, 16'h9900, 1);
    // Array goes idle at once; recovery alone must keep busy up
    op_busy = 1'b0;
    repeat (2) @(negedge ref_clk);
    `CHK(abort_cnt, 1)
    `CHK(quad_mode, 1'b0)
    `CHK(status, 8'hA5)
    repeat (24) @(negedge ref_clk);
    `CHK(status, 8'hA4)
    frame(1'b0, 16'h6600, 1);
    frame(1'b0, 16'h9900, 1);
    `CHK(dpd_cnt, 2)
    `CHK(abort_cnt, 1)
    `CHK(status, 8'hA4)
    finish_test();
  end
endmodule
`default_nettype wire
